// ---- include/utxb_pkg.sv ----
// Package for the UART transmit buffering and interrupt control slice.
// Assumes a single 20 MHz system clock and an 8-bit register port.
package utxb_pkg;

  // ****************************************************************
  // Register map and field positions
  // ****************************************************************
  localparam logic [3:0] UTXB_ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] UTXB_ADDR_TX_DATA        = 4'h1;
  localparam logic [3:0] UTXB_ADDR_RX_DATA        = 4'h2;
  localparam logic [3:0] UTXB_ADDR_MODE           = 4'h3;
  localparam int UTXB_BIT_DBL_BUF     = 7;
  localparam int UTXB_BIT_IRQ_STOPEND = 6;
  localparam int UTXB_BIT_SPLIT_IRQ   = 5;
  localparam int UTXB_BIT_TX_IRQ      = 1;
  localparam int UTXB_BIT_RX_IRQ      = 0;
  localparam int UTXB_BIT_MODE0       = 0;
  localparam logic [7:0] UTXB_RESET_CTRL  = 8'h00;
  localparam logic [7:0] UTXB_READ_UNMAP  = 8'h00;
  localparam logic [7:0] UTXB_STOP_LEVEL  = 8'hFF;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int UTXB_CLK_HZ   = 20000000;
  localparam int UTXB_BAUD     = 115200;
  localparam int UTXB_BIT_CYC  = UTXB_CLK_HZ / UTXB_BAUD;
  localparam int UTXB_FRAME_BITS = 10;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } utxb_bus_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } utxb_word_t;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} utxb_tx_state_t;

endpackage

// ---- rtl/utxb_buf2.sv ----
// Two-entry valid/ready buffer for transmit words.
// Assumes both sides run on clk_in; depth fixed at two.
`timescale 1ns/1ps
`default_nettype none
module utxb_buf2
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Filling side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Draining side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0]            cnt;
  } utxb_buf_state_t;

  utxb_buf_state_t st_reg;
  utxb_buf_state_t st_next;
  logic            push;
  logic            pop;

  always_comb
  begin
    st_next = st_reg;
    push = in_valid_in && (st_reg.cnt != 2'h2);
    pop  = out_ready_in && (st_reg.cnt != 2'h0);
    if (pop)
    begin
      st_next.mem[0] = st_reg.mem[1];
    end
    if (push)
    begin
      st_next.mem[pop ? 1'b0 : st_reg.cnt[0]] = in_data_in;
    end
    st_next.cnt = 2'(st_reg.cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign in_ready_out  = (st_reg.cnt != 2'h2);
  assign out_valid_out = (st_reg.cnt != 2'h0);
  assign out_data_out  = st_reg.mem[0];

endmodule
`default_nettype wire

// ---- rtl/utxb_ctrl.sv ----
// UART transmit buffering and interrupt control with a simple transmitter.
// Assumes a register master on clk_in and a receive datapath outside that
// delivers received bytes as one-cycle pulses.
//
// Notes on behaviour
// - With the double-buffer bit at 1 the transmitter holds three words (two buffered, one shifting), at 0 only one.
// - The double-buffer bit resets to 0 so the port behaves as a legacy single buffer.
// - The transmit event comes at the start of the stop bit when the timing bit is 0, at its end when 1.
// - Single buffering with the event at stop end may leave an idle gap before the next start bit.
// - With the split bit at 1 receive and transmit requests leave on separate outputs.
// - With the split bit at 0 both events share one request, and the bit resets to 0.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module utxb_ctrl
  import utxb_pkg::*;
#(
  parameter int BIT_CYC = utxb_pkg::UTXB_BIT_CYC
)
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Register port
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic [7:0]      rdata_out,
  // Receive event source
  input  wire logic       rx_valid_in,
  input  wire logic [7:0] rx_data_in,
  // Serial line and requests
  output logic            txd_out,
  output logic            irq_shared_out,
  output logic            irq_rx_out,
  output logic            irq_tx_out,
  output logic            tx_ready_out
);
  import utxb_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                  tx_double_buffer_enable;
    logic                  tx_irq_at_stop_end;
    logic                  split_rx_tx_irq;
    logic                  mode0;
    logic                  tx_pend;
    logic                  rx_pend;
    logic [7:0]            rx_byte;
    logic [7:0]            rdata;
    utxb_tx_state_t        tx_st;
    logic [7:0]            shifter;
    logic [2:0]            bit_idx;
    logic [15:0]           baud_cnt;
    logic                  txd;
    logic                  irq_shared;
    logic                  irq_rx;
    logic                  irq_tx;
    logic                  wr_ready;
  } utxb_ctrl_state_t;

  utxb_ctrl_state_t st_reg;
  utxb_ctrl_state_t st_next;

  logic       buf_in_valid;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic [7:0] buf_out_data;
  logic       buf_take;
  logic       buf_push;
  logic       buf_empty_next;
  logic       buf_full_next;
  logic       admit_single;
  logic       bit_tick;
  logic       tx_event;
  logic [7:0] status_word;
  logic       wr_ctrl;
  logic       wr_data;
  logic       wr_mode;
  logic       rd_ctrl;
  logic       rd_rx;
  logic       rd_mode;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    hit = (a == target);
  endfunction

  // ****************************************************************
  // Status word
  // ****************************************************************
  // Field positions come from the package, so the map lives in one place.
  function automatic logic [7:0] pack_status(input utxb_ctrl_state_t s);
    logic [7:0] w;
    w                       = '0;
    w[UTXB_BIT_DBL_BUF]     = s.tx_double_buffer_enable;
    w[UTXB_BIT_IRQ_STOPEND] = s.tx_irq_at_stop_end;
    w[UTXB_BIT_SPLIT_IRQ]   = s.split_rx_tx_irq;
    w[UTXB_BIT_TX_IRQ]      = s.tx_pend;
    w[UTXB_BIT_RX_IRQ]      = s.rx_pend;
    pack_status             = w;
  endfunction

  // ****************************************************************
  // Register decode
  // ****************************************************************
  // Each strobe is qualified once, so every consumer sees the same select.
  assign wr_ctrl = wr_in && hit(addr_in, UTXB_ADDR_STATUS_CONTROL);
  assign wr_data = wr_in && hit(addr_in, UTXB_ADDR_TX_DATA);
  assign wr_mode = wr_in && hit(addr_in, UTXB_ADDR_MODE);
  assign rd_ctrl = rd_in && hit(addr_in, UTXB_ADDR_STATUS_CONTROL);
  assign rd_rx   = rd_in && hit(addr_in, UTXB_ADDR_RX_DATA);
  assign rd_mode = rd_in && hit(addr_in, UTXB_ADDR_MODE);

  // ****************************************************************
  // Transmit buffer
  // ****************************************************************
  // Single buffering admits a new word only when buffer and shifter are empty.
  assign admit_single = !buf_out_valid && (st_reg.tx_st == TX_IDLE);
  assign buf_in_valid = wr_data && (st_reg.tx_double_buffer_enable || admit_single);

  utxb_buf2 #(.WIDTH(8)) u_buf
  (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (buf_in_valid),
    .in_data_in    (wdata_in),
    .in_ready_out  (buf_in_ready),
    .out_valid_out (buf_out_valid),
    .out_data_out  (buf_out_data),
    .out_ready_in  (buf_take)
  );

  assign buf_take       = (st_reg.tx_st == TX_IDLE) && buf_out_valid;
  assign buf_push       = buf_in_valid && buf_in_ready;
  assign buf_empty_next = !buf_push && (!buf_out_valid || (buf_in_ready && buf_take));
  assign buf_full_next  = (!buf_in_ready && !buf_take) || (buf_out_valid && buf_push && !buf_take);
  assign status_word    = pack_status(st_reg);

  // ****************************************************************
  // Baud divider
  // ****************************************************************
  // The count rests at zero between frames, so every frame starts on a full bit.
  assign bit_tick = (st_reg.baud_cnt == 16'(BIT_CYC - 1));

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    // No event unless a frame reaches the selected edge of its stop bit.
    tx_event = 1'b0;
    st_next.baud_cnt = (st_reg.tx_st == TX_IDLE || bit_tick) ? 16'h0000 : 16'(st_reg.baud_cnt + 16'h0001);
    case (st_reg.tx_st)
      TX_IDLE:
      begin
        st_next.txd = 1'b1;
        if (buf_out_valid)
        begin
          st_next.shifter = buf_out_data;
          st_next.tx_st   = TX_START;
          st_next.txd     = 1'b0;
        end
      end
      TX_START:
      begin
        if (bit_tick)
        begin
          st_next.tx_st   = TX_DATA;
          st_next.bit_idx = 3'h0;
          st_next.txd     = st_reg.shifter[0];
        end
      end
      TX_DATA:
      begin
        if (bit_tick)
        begin
          if (st_reg.bit_idx == 3'h7)
          begin
            st_next.tx_st = TX_STOP;
            st_next.txd   = UTXB_STOP_LEVEL[0];
            tx_event      = !st_reg.tx_irq_at_stop_end;
          end
          else
          begin
            st_next.bit_idx = 3'(st_reg.bit_idx + 3'h1);
            st_next.txd     = st_reg.shifter[3'(st_reg.bit_idx + 3'h1)];
          end
        end
      end
      TX_STOP:
      begin
        if (bit_tick)
        begin
          // The next start bit waits for a fresh word, hence a possible gap.
          st_next.tx_st = TX_IDLE;
          tx_event      = st_reg.tx_irq_at_stop_end;
        end
      end
      default:
      begin
        st_next.tx_st = TX_IDLE;
      end
    endcase

    st_next.rdata = UTXB_READ_UNMAP;
    if (rd_ctrl)
    begin
      st_next.rdata = status_word;
    end
    else if (rd_rx)
    begin
      st_next.rdata = st_reg.rx_byte;
    end
    else if (rd_mode)
    begin
      st_next.rdata = {7'h00, st_reg.mode0};
    end

    if (wr_ctrl)
    begin
      st_next.tx_double_buffer_enable = wdata_in[UTXB_BIT_DBL_BUF];
      st_next.tx_irq_at_stop_end      = wdata_in[UTXB_BIT_IRQ_STOPEND];
      st_next.split_rx_tx_irq         = wdata_in[UTXB_BIT_SPLIT_IRQ];
      // Writing one to a pending bit clears it.
      if (wdata_in[UTXB_BIT_TX_IRQ])
      begin
        st_next.tx_pend = 1'b0;
      end
      if (wdata_in[UTXB_BIT_RX_IRQ])
      begin
        st_next.rx_pend = 1'b0;
      end
    end
    if (wr_mode)
    begin
      st_next.mode0 = wdata_in[UTXB_BIT_MODE0];
    end
    // Set wins over a clear in the same cycle.
    if (tx_event)
    begin
      st_next.tx_pend = 1'b1;
    end
    if (rx_valid_in)
    begin
      st_next.rx_pend = 1'b1;
      st_next.rx_byte = rx_data_in;
    end

    st_next.irq_shared = !st_next.split_rx_tx_irq && (st_next.rx_pend || st_next.tx_pend);
    st_next.irq_rx     = st_next.split_rx_tx_irq && st_next.rx_pend;
    st_next.irq_tx     = st_next.split_rx_tx_irq && st_next.tx_pend;
    // Readiness is judged on the buffer as it stands after this edge, so a word
    // that lands now already counts against the next writer.
    if (st_next.tx_double_buffer_enable)
    begin
      st_next.wr_ready = !buf_full_next;
    end
    else
    begin
      st_next.wr_ready = (st_next.tx_st == TX_IDLE) && buf_empty_next;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_reg       <= '0;
      // The line idles high through reset so the far end sees no false start bit.
      st_reg.txd   <= 1'b1;
      st_reg.tx_double_buffer_enable <= UTXB_RESET_CTRL[UTXB_BIT_DBL_BUF];
      st_reg.tx_irq_at_stop_end      <= UTXB_RESET_CTRL[UTXB_BIT_IRQ_STOPEND];
      st_reg.split_rx_tx_irq         <= UTXB_RESET_CTRL[UTXB_BIT_SPLIT_IRQ];
      st_reg.tx_st <= TX_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output is a plain register copy, so nothing downstream sees a glitch.
  assign rdata_out      = st_reg.rdata;
  assign txd_out        = st_reg.txd;
  assign irq_shared_out = st_reg.irq_shared;
  assign irq_rx_out     = st_reg.irq_rx;
  assign irq_tx_out     = st_reg.irq_tx;
  assign tx_ready_out   = st_reg.wr_ready;

endmodule
`default_nettype wire

// ---- tb/utxb_ctrl_asserts.sv ----
// Checker for the transmit buffering and interrupt control slice.
// Assumes a master that never strobes write and read at once.
`timescale 1ns/1ps
`default_nettype none
module utxb_ctrl_chk
(
  // Watched ports
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic [7:0] rdata_out,
  input  wire logic       rx_valid_in,
  input  wire logic       irq_shared_out,
  input  wire logic       irq_rx_out,
  input  wire logic       irq_tx_out,
  input  wire logic       txd_out,
  input  wire logic       tx_ready_out
);
  // Mirror of the three control bits, so requests can be judged.
  logic [2:0] c_reg;
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      c_reg <= 3'h0;
    else if (wr_in && addr_in == 4'h0)
      c_reg <= wdata_in[7:5];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_ctrl_readback: assert property ($past(rd_in && addr_in == 4'h0) |-> rdata_out[7:5] == $past(c_reg))
    else $error("control bits read back wrong");
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read slot");
  a_unmap_zero: assert property ($past(rd_in && addr_in > 4'h3) |-> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_shared_gate: assert property (irq_shared_out |-> !c_reg[0])
    else $error("shared request while split");
  a_split_gate: assert property (irq_rx_out || irq_tx_out |-> c_reg[0])
    else $error("split request while merged");
  a_rx_shared: assert property (rx_valid_in && !c_reg[0] && !wr_in ##1 !wr_in |-> ##1 irq_shared_out)
    else $error("receive event missing on shared request");
  a_rx_split: assert property (rx_valid_in && c_reg[0] && !wr_in ##1 !wr_in |-> ##1 irq_rx_out && !irq_shared_out)
    else $error("receive event missing on own request");
  a_single_busy: assert property (!txd_out && !c_reg[2] && !$past(c_reg[2]) |-> !tx_ready_out)
    else $error("single buffer took a word while sending");
  cover property (rx_valid_in && c_reg[0]);
  cover property ($rose(irq_tx_out));
  cover property ($rose(irq_shared_out));
endmodule
bind utxb_ctrl utxb_ctrl_chk u_chk (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .rx_valid_in, .irq_shared_out, .irq_rx_out, .irq_tx_out, .txd_out, .tx_ready_out);
`default_nettype wire

// ---- tb/utxb_rx_model.sv ----
// Serial receiver at the far end of the transmit line.
// Assumes 8 data bits, LSB first, one stop bit, bit length BIT_CYC.
`timescale 1ns/1ps
`default_nettype none
module utxb_rx_model
#(
  parameter int BIT_CYC = 4
)
(
  input  wire logic       clk_in,
  input  wire logic       txd_in,
  output logic            valid_out,
  output logic [7:0]      data_out
);
  initial valid_out = 1'b0;
  initial data_out = 8'h00;
  always
  begin
    @(negedge txd_in);
    repeat (BIT_CYC / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge clk_in);
      data_out[i] <= txd_in;
    end
    repeat (BIT_CYC) @(posedge clk_in);
    // A low stop bit drops the byte, so a framing slip shows as a lost word.
    valid_out <= txd_in;
    @(posedge clk_in);
    valid_out <= 1'b0;
  end
endmodule
`default_nettype wire

// ---- tb/utxb_ctrl_tb.sv ----
// Self-checking bench for the transmit buffering and interrupt slice.
// Assumes the far-end receiver model and a shortened bit length.
`timescale 1ns/1ps
`default_nettype none
module utxb_ctrl_tb;
  import utxb_pkg::*;
  localparam int BC = 4;
  logic clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, rx_valid_in = 1'b0, rd_d = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00, rx_data_in = 8'h00, rdata_out, m_data, r;
  logic txd_out, irq_shared_out, irq_rx_out, irq_tx_out, tx_ready_out, m_valid;
  int error_cnt = 0, cmp_count = 0, d;
  logic [7:0] rd_q[$], tx_q[$];
  utxb_ctrl #(.BIT_CYC(BC)) dut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .rx_valid_in, .rx_data_in, .txd_out, .irq_shared_out, .irq_rx_out, .irq_tx_out, .tx_ready_out);
  utxb_rx_model #(.BIT_CYC(BC)) far (.clk_in, .txd_in(txd_out), .valid_out(m_valid), .data_out(m_data));
  initial forever #25 clk_in = ~clk_in;
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task wait_tx(input logic l);
    d = 0;
    while (txd_out !== l && d < 500)
    begin
      @(posedge clk_in);
      d++;
    end
    chk("txd_wait", 8'(l), 8'(txd_out));
  endtask
  task pulse_rx(input logic [7:0] v);
    rx_data_in <= v;
    rx_valid_in <= 1'b1;
    @(posedge clk_in);
    rx_valid_in <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  // Single buffer: a second word is refused; the event lag is measured from the stop bit.
  task tx_timed(input logic [7:0] c, input int e);
    wr(UTXB_ADDR_STATUS_CONTROL, c | 8'h03);
    tx_q.push_back(8'h00);
    wr(UTXB_ADDR_TX_DATA, 8'h00);
    chk("tx_ready", 8'h00, tx_ready_out);
    @(posedge clk_in);
    chk("tx_ready", 8'h00, tx_ready_out);
    wr(UTXB_ADDR_TX_DATA, 8'hA5);
    wait_tx(1'b0);
    wait_tx(1'b1);
    d = 0;
    while (irq_tx_out !== 1'b1 && d < 500)
    begin
      @(posedge clk_in);
      d++;
    end
    chk("tx_delay", 8'(e), 8'(d));
    wr(UTXB_ADDR_STATUS_CONTROL, c | 8'h03);
    repeat (3 * BC) @(posedge clk_in);
  endtask
  task wrap_up;
    chk("tx_left", 8'h00, 8'(tx_q.size()));
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    if (rd_d)
      chk("rdata", rd_q.pop_front(), rdata_out);
    rd_d = rd_in;
    if (m_valid && tx_q.size() == 0)
      chk("tx_extra", 8'h00, 8'h01);
    else if (m_valid)
      chk("tx_byte", tx_q.pop_front(), m_data);
  end
  initial
  begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    wrap_up;
  end
  initial
  begin
    void'($urandom(32'h50A1));
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rd(UTXB_ADDR_STATUS_CONTROL, UTXB_RESET_CTRL);
    rd(4'hF, UTXB_READ_UNMAP);
    for (int v = 0; v < 8; v++)
    begin
      wr(UTXB_ADDR_STATUS_CONTROL, {v[2:0], 5'h03});
      rd(UTXB_ADDR_STATUS_CONTROL, {v[2:0], 5'h00});
    end
    wr(UTXB_ADDR_STATUS_CONTROL, 8'h03);
    wr(UTXB_ADDR_MODE, 8'h01);
    rd(UTXB_ADDR_MODE, 8'h01);
    wr(UTXB_ADDR_MODE, 8'h00);
    tx_timed(8'h20, 0);
    tx_timed(8'h60, BC);
    wr(UTXB_ADDR_STATUS_CONTROL, 8'hA3);
    for (int i = 0; i < 3; i++)
    begin
      d = 0;
      while (tx_ready_out !== 1'b1 && d < 500)
      begin
        @(posedge clk_in);
        d++;
      end
      chk("tx_ready_wait", 8'h01, 8'(tx_ready_out));
      r = 8'($urandom);
      tx_q.push_back(r);
      wr(UTXB_ADDR_TX_DATA, r);
      if (i == 2)
        chk("tx_ready_full", 8'h00, tx_ready_out);
      if (i == 0)
        wait_tx(1'b0);
      if (i == 0)
        chk("tx_ready_dbl", 8'h01, tx_ready_out);
    end
    repeat (40 * BC) @(posedge clk_in);
    r = 8'($urandom);
    wr(UTXB_ADDR_STATUS_CONTROL, 8'h03);
    pulse_rx(r);
    chk("irq_shared", 8'h01, irq_shared_out);
    chk("irq_rx", 8'h00, irq_rx_out);
    rd(UTXB_ADDR_RX_DATA, r);
    wr(UTXB_ADDR_STATUS_CONTROL, 8'h01);
    @(posedge clk_in);
    chk("irq_shared", 8'h00, irq_shared_out);
    wr(UTXB_ADDR_STATUS_CONTROL, 8'h20);
    pulse_rx(r);
    chk("irq_rx", 8'h01, irq_rx_out);
    chk("irq_shared", 8'h00, irq_shared_out);
    wr(UTXB_ADDR_STATUS_CONTROL, 8'h21);
    wrap_up;
  end
endmodule
`default_nettype wire
